// ---- eeprom_ctl_pkg.sv ----
`default_nettype none
package eeprom_ctl_pkg;
    localparam int unsigned CLK_HZ         = 50_000_000;
    localparam int unsigned ADDR_W         = 9;
    localparam int unsigned DATA_W         = 8;
    localparam int unsigned PULSE_MIN_MS   = 1;
    localparam int unsigned PULSE_MAX_MS   = 10;
    localparam int unsigned VPP_SETUP_US   = 5;
    localparam int unsigned ADDR_SETUP_NS  = 260;
    localparam int unsigned ACCESS_NS      = 825;
    localparam int unsigned STROBE_HIGH_NS = 1400;
    localparam int unsigned SETTLE_US      = 100;
    localparam int unsigned PULSE_CYC      = PULSE_MIN_MS * (CLK_HZ / 1000);
    localparam int unsigned VPP_CYC        = (VPP_SETUP_US * (CLK_HZ / 1000) + 999) / 1000;
    localparam int unsigned ASU_CYC        = (ADDR_SETUP_NS * (CLK_HZ / 1000000) + 999) / 1000;
    localparam int unsigned ACC_CYC        = (ACCESS_NS * (CLK_HZ / 1000000) + 999) / 1000;
    localparam int unsigned CEH_CYC        = (STROBE_HIGH_NS * (CLK_HZ / 1000000) + 999) / 1000;
    localparam int unsigned SETTLE_CYC     = SETTLE_US * (CLK_HZ / 1000000);
    localparam int unsigned CNT_W          = 20;

    typedef enum logic [1:0] {
        OP_READ,
        OP_ERASE,
        OP_PROGRAM
    } op_t;

    typedef struct packed {
        op_t               op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } req_t;

    typedef struct packed {
        logic              part_select;
        logic              latch_strobe_n;
        logic              drive_gate_n;
        logic              program_level;
        logic [ADDR_W-1:0] byte_addr;
        logic [DATA_W-1:0] data_out;
        logic              data_oe_n;
    } pins_t;
endpackage : eeprom_ctl_pkg
`default_nettype wire

// ---- cycle_timer.sv ----
`timescale 1ns/100ps
`default_nettype none
module cycle_timer #(
    parameter int unsigned W = 20
) (
    input  wire logic         mclk,    // Clock
    input  wire logic         sys_rst, // Reset
    input  wire logic         load,    // Start count
    input  wire logic [W-1:0] count,   // Cycles to wait
    output logic              done     // Count reached zero
);
    typedef struct packed {
        logic [W-1:0] cnt;
    } tstate_t;
    tstate_t s_q;
    tstate_t s_d;

    always_comb
    begin
        s_d = s_q;
        if (load)
        begin
            s_d.cnt = count;
        end
        else if (s_q.cnt != '0)
        begin
            s_d.cnt = s_q.cnt - W'(1);
        end
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // From the register only: callers derive load from done in the same cycle
    assign done = (s_q.cnt == '0);
endmodule : cycle_timer
`default_nettype wire

// ---- eeprom_mode_control.sv ----
`timescale 1ns/100ps
`default_nettype none
module eeprom_mode_control #(
    parameter int unsigned PULSE_CYCLES  = eeprom_ctl_pkg::PULSE_CYC,
    parameter int unsigned SETTLE_CYCLES = eeprom_ctl_pkg::SETTLE_CYC
) (
    input  wire logic                              mclk,           // Clock 50 MHz
    input  wire logic                              sys_rst,        // Sync reset, high
    input  wire logic                              req_valid,      // Request offered
    output logic                                   req_ready,      // Idle, takes request
    input  wire eeprom_ctl_pkg::req_t              req,            // Operation, address, data
    output logic                                   rd_valid,       // Read data pulse
    output logic [eeprom_ctl_pkg::DATA_W-1:0]      rd_data,        // Read byte
    output logic                                   part_select,    // Select pin
    output logic                                   latch_strobe_n, // Address latch strobe
    output logic                                   drive_gate_n,   // Output gate / erase
    output logic                                   program_level,  // Raise supply to program
    output logic [eeprom_ctl_pkg::ADDR_W-1:0]      byte_addr,      // Address pins
    output logic [eeprom_ctl_pkg::DATA_W-1:0]      data_out,       // Data pin drive value
    output logic                                   data_oe_n,      // Data drive enable, low
    input  wire logic [eeprom_ctl_pkg::DATA_W-1:0] data_in         // Data pin level
);
    localparam int unsigned W = eeprom_ctl_pkg::CNT_W;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_SETUP,
        ST_VPP,
        ST_PULSE,
        ST_RECOVER,
        ST_SETTLE,
        ST_ACCESS,
        ST_CAPTURE,
        ST_GAP
    } phase_t;

    typedef struct packed {
        phase_t                            phase;
        eeprom_ctl_pkg::op_t               op;
        eeprom_ctl_pkg::pins_t             pins;
        logic [eeprom_ctl_pkg::DATA_W-1:0] rd_data;
        logic                              rd_valid;
        logic                              at_vpp;
    } state_t;

    state_t s_q;
    state_t s_d;
    logic [eeprom_ctl_pkg::DATA_W-1:0] din_meta_q;
    logic [eeprom_ctl_pkg::DATA_W-1:0] din_sync_q;
    logic         t_load;
    logic [W-1:0] t_count;
    logic         t_done;

    cycle_timer #(.W(W)) u_timer (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .load    (t_load),
        .count   (t_count),
        .done    (t_done)
    );

    always_ff @(posedge mclk)
    begin
        din_meta_q <= data_in;
        din_sync_q <= din_meta_q;
    end

    always_comb
    begin
        s_d          = s_q;
        s_d.rd_valid = 1'b0;
        t_load       = 1'b0;
        t_count      = '0;
        unique case (s_q.phase)
            ST_IDLE:
            begin
                if (req_valid)
                begin
                    s_d.op                  = req.op;
                    s_d.pins.byte_addr      = req.addr;
                    s_d.pins.data_out       = req.data;
                    s_d.pins.latch_strobe_n = 1'b1;
                    s_d.pins.drive_gate_n   = 1'b1;
                    s_d.pins.data_oe_n      = 1'b1;
                    if (req.op == eeprom_ctl_pkg::OP_READ && s_q.at_vpp)
                    begin
                        // Drop supply first and let it settle
                        s_d.pins.program_level = 1'b0;
                        s_d.at_vpp             = 1'b0;
                        t_load                 = 1'b1;
                        t_count                = W'(SETTLE_CYCLES);
                        s_d.phase              = ST_SETTLE;
                    end
                    else
                    begin
                        // Select rises with strobe and gate high, so pulses are edge-timed
                        s_d.pins.part_select = 1'b1;
                        t_load               = 1'b1;
                        t_count              = W'(eeprom_ctl_pkg::ASU_CYC);
                        s_d.phase            = ST_SETUP;
                    end
                end
            end
            ST_SETTLE:
            begin
                if (t_done)
                begin
                    s_d.pins.part_select = 1'b1;
                    t_load               = 1'b1;
                    t_count              = W'(eeprom_ctl_pkg::ASU_CYC);
                    s_d.phase            = ST_SETUP;
                end
            end
            ST_SETUP:
            begin
                if (t_done)
                begin
                    if (s_q.op == eeprom_ctl_pkg::OP_READ)
                    begin
                        // Strobe fall latches the address
                        s_d.pins.latch_strobe_n = 1'b0;
                        s_d.pins.drive_gate_n   = 1'b0;
                        t_load                  = 1'b1;
                        t_count                 = W'(eeprom_ctl_pkg::ACC_CYC);
                        s_d.phase               = ST_ACCESS;
                    end
                    else if (s_q.at_vpp)
                    begin
                        // Supply already high: successive operations
                        t_load    = 1'b1;
                        t_count   = W'(eeprom_ctl_pkg::VPP_CYC);
                        s_d.phase = ST_VPP;
                    end
                    else
                    begin
                        s_d.pins.program_level = 1'b1;
                        s_d.at_vpp             = 1'b1;
                        t_load                 = 1'b1;
                        t_count                = W'(eeprom_ctl_pkg::VPP_CYC);
                        s_d.phase              = ST_VPP;
                    end
                end
            end
            ST_VPP:
            begin
                if (t_done)
                begin
                    if (s_q.op == eeprom_ctl_pkg::OP_ERASE)
                    begin
                        s_d.pins.drive_gate_n = 1'b0;
                    end
                    else
                    begin
                        // Only one of strobe and gate ever goes low here
                        s_d.pins.data_oe_n      = 1'b0;
                        s_d.pins.latch_strobe_n = 1'b0;
                    end
                    t_load    = 1'b1;
                    t_count   = W'(PULSE_CYCLES);
                    s_d.phase = ST_PULSE;
                end
            end
            ST_PULSE:
            begin
                if (t_done)
                begin
                    s_d.pins.drive_gate_n   = 1'b1;
                    s_d.pins.latch_strobe_n = 1'b1;
                    t_load                  = 1'b1;
                    t_count                 = W'(eeprom_ctl_pkg::ASU_CYC);
                    s_d.phase               = ST_RECOVER;
                end
            end
            ST_RECOVER:
            begin
                // Data held past the strobe rise before release
                if (t_done)
                begin
                    s_d.pins.data_oe_n   = 1'b1;
                    s_d.pins.part_select = 1'b0;
                    t_load               = 1'b1;
                    t_count              = W'(eeprom_ctl_pkg::CEH_CYC);
                    s_d.phase            = ST_GAP;
                end
            end
            ST_ACCESS:
            begin
                if (t_done)
                begin
                    s_d.phase = ST_CAPTURE;
                end
            end
            ST_CAPTURE:
            begin
                // Two cycles extra for the pin synchroniser
                if (t_done)
                begin
                    s_d.rd_data             = din_sync_q;
                    s_d.rd_valid            = 1'b1;
                    s_d.pins.latch_strobe_n = 1'b1;
                    s_d.pins.drive_gate_n   = 1'b1;
                    s_d.pins.part_select    = 1'b0;
                    t_load                  = 1'b1;
                    t_count                 = W'(eeprom_ctl_pkg::CEH_CYC);
                    s_d.phase               = ST_GAP;
                end
            end
            ST_GAP:
            begin
                if (t_done)
                begin
                    s_d.phase = ST_IDLE;
                end
            end
            default:
            begin
                s_d.phase = ST_IDLE;
            end
        endcase
        if (s_q.phase == ST_ACCESS && t_done)
        begin
            t_load  = 1'b1;
            t_count = W'(2);
        end
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            s_q                     <= '0;
            s_q.phase               <= ST_IDLE;
            s_q.op                  <= eeprom_ctl_pkg::OP_READ;
            s_q.pins.latch_strobe_n <= 1'b1;
            s_q.pins.drive_gate_n   <= 1'b1;
            s_q.pins.data_oe_n      <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign req_ready      = (s_q.phase == ST_IDLE);
    assign rd_valid       = s_q.rd_valid;
    assign rd_data        = s_q.rd_data;
    assign part_select    = s_q.pins.part_select;
    assign latch_strobe_n = s_q.pins.latch_strobe_n;
    assign drive_gate_n   = s_q.pins.drive_gate_n;
    assign program_level  = s_q.pins.program_level;
    assign byte_addr      = s_q.pins.byte_addr;
    assign data_out       = s_q.pins.data_out;
    assign data_oe_n      = s_q.pins.data_oe_n;
endmodule : eeprom_mode_control
`default_nettype wire

// ---- eeprom_mode_control_assertions.sv ----
`timescale 1ns/100ps
`default_nettype none
module eeprom_mode_control_chk #(
    parameter int unsigned PULSE_CYCLES  = 20,
    parameter int unsigned SETTLE_CYCLES = 10
) (
    input  wire logic                              mclk,           // Clock
    input  wire logic                              sys_rst,        // Reset
    input  wire logic                              req_valid,      // Request offered
    input  wire logic                              req_ready,      // Idle
    input  wire eeprom_ctl_pkg::req_t              req,            // Request
    input  wire logic                              rd_valid,       // Read pulse
    input  wire logic                              part_select,    // Select
    input  wire logic                              latch_strobe_n, // Strobe
    input  wire logic                              drive_gate_n,   // Gate
    input  wire logic                              program_level,  // Supply raised
    input  wire logic [eeprom_ctl_pkg::ADDR_W-1:0] byte_addr,      // Address
    input  wire logic [eeprom_ctl_pkg::DATA_W-1:0] data_out,       // Data drive
    input  wire logic                              data_oe_n       // Drive enable
);
    logic        pulse;
    logic        pulse_q;
    logic [31:0] wid_q;
    logic [31:0] since_q;
    // Erase or program pulse in progress
    assign pulse = program_level && (!drive_gate_n || !latch_strobe_n);
    always_ff @(posedge mclk)
    begin
        pulse_q <= sys_rst ? 1'b0 : pulse;
        wid_q   <= (sys_rst || !pulse) ? 32'h0 : wid_q + 32'h1;
        since_q <= sys_rst ? 32'hffffffff : program_level ? 32'h0 :
                   (since_q == 32'hffffffff) ? since_q : since_q + 32'h1;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    sequence s_read_take;
        req_valid && req_ready && req.op == eeprom_ctl_pkg::OP_READ;
    endsequence
    sequence s_read_done;
        ##[1:100] rd_valid;
    endsequence
    AST_NO_PROHIBITED:
    assert property (program_level |-> !(part_select && !latch_strobe_n && !drive_gate_n))
        else $error("prohibited pin combination at program level");
    AST_ERASE_PINS:
    assert property ($fell(drive_gate_n) && program_level |-> part_select && latch_strobe_n)
        else $error("erase pulse with wrong pins");
    AST_PROG_PINS:
    assert property ($fell(latch_strobe_n) && program_level |->
                     part_select && drive_gate_n && !data_oe_n)
        else $error("program pulse with wrong pins");
    AST_SUPPLY_FIRST:
    assert property ($rose(program_level) |-> (drive_gate_n && latch_strobe_n)[*8])
        else $error("pulse too soon after supply raise");
    AST_PULSE_WIDTH:
    assert property (pulse_q && !pulse |-> wid_q >= PULSE_CYCLES && wid_q <= 10 * PULSE_CYCLES)
        else $error("pulse width out of range");
    AST_ADDR_SETUP:
    assert property ($fell(latch_strobe_n) |-> $past(part_select) && $stable(byte_addr))
        else $error("address not set up before strobe");
    AST_HOLD_LOW:
    assert property (!latch_strobe_n && !$past(latch_strobe_n) |->
                     $stable(byte_addr) && (data_oe_n || $stable(data_out)))
        else $error("address or data moved while strobe low");
    AST_SETTLE:
    assert property ($fell(latch_strobe_n) && !program_level |-> since_q >= SETTLE_CYCLES)
        else $error("read before supply settled");
    AST_READ_ANSWER:
    assert property (s_read_take |-> s_read_done)
        else $error("read gave no answer");
    AST_READ_GATED:
    assert property (rd_valid |-> !program_level && !$past(drive_gate_n) && $past(part_select))
        else $error("read data taken without output gate");
    AST_IDLE_PINS:
    assert property (req_ready |-> !part_select && latch_strobe_n && drive_gate_n && data_oe_n)
        else $error("pins active while idle");
endmodule : eeprom_mode_control_chk
bind eeprom_mode_control eeprom_mode_control_chk #(
    .PULSE_CYCLES(PULSE_CYCLES), .SETTLE_CYCLES(SETTLE_CYCLES)
) u_chk (.mclk, .sys_rst, .req_valid, .req_ready, .req, .rd_valid, .part_select,
    .latch_strobe_n, .drive_gate_n, .program_level, .byte_addr, .data_out, .data_oe_n);
`default_nettype wire

// ---- eeprom_dev_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module eeprom_dev_model #(
    parameter time PULSE_MIN_NS = 400,
    parameter time SETTLE_NS    = 200
) (
    input  wire logic       part_select,    // Select
    input  wire logic       latch_strobe_n, // Address latch strobe
    input  wire logic       drive_gate_n,   // Output gate / erase
    input  wire logic       program_level,  // Supply at program level
    input  wire logic [8:0] byte_addr,      // Address
    input  wire logic [7:0] bus_in,         // Resolved data lines
    output logic [7:0]      dev_data,       // Data out, inverted while floating
    output logic            dev_oe_n,       // Low while driving
    output logic            fault           // Host misuse seen
);
    logic [7:0] mem [512];
    logic [7:0] latched = 8'h00;
    logic [8:0] prog_a;
    logic       e_act = 1'b0;
    logic       p_act = 1'b0;
    logic       erase_on;
    logic       prog_on;
    time        t_e, t_p;
    time        t_drop = 0;
    initial
    begin
        fault = 1'b0;
        for (int i = 0; i < 512; i++)
            mem[i] = i[7:0] ^ {7'h0, i[8]} ^ 8'h5a;
    end
    assign erase_on = part_select && program_level && !drive_gate_n && latch_strobe_n;
    assign prog_on  = part_select && program_level && !latch_strobe_n && drive_gate_n;
    assign dev_oe_n = !(part_select && !latch_strobe_n && !drive_gate_n && !program_level);
    assign dev_data = dev_oe_n ? ~latched : latched;
    always @(posedge erase_on)
    begin
        t_e = $time;
        e_act = 1'b1;
    end
    always @(negedge erase_on)
        if (e_act)
        begin
            e_act = 1'b0;
            if ($time - t_e < PULSE_MIN_NS || $time - t_e > 10 * PULSE_MIN_NS)
                fault = 1'b1;
            for (int i = 0; i < 512; i++)
                mem[i] = 8'h00;
        end
    always @(posedge prog_on)
    begin
        t_p = $time;
        prog_a = byte_addr;
        p_act = 1'b1;
    end
    always @(negedge prog_on)
        if (p_act)
        begin
            p_act = 1'b0;
            if ($time - t_p < PULSE_MIN_NS || $time - t_p > 10 * PULSE_MIN_NS)
                fault = 1'b1;
            mem[prog_a] = mem[prog_a] | bus_in;
        end
    always @(negedge program_level)
        t_drop = $time;
    always @(negedge latch_strobe_n or posedge part_select)
        if (part_select && !latch_strobe_n && !program_level)
        begin
            if ($time - t_drop < SETTLE_NS)
                fault = 1'b1;
            latched = mem[byte_addr];
        end
    always @(*)
        if (program_level && part_select && !latch_strobe_n && !drive_gate_n)
            fault = 1'b1;
endmodule : eeprom_dev_model
`default_nettype wire

// ---- test_eeprom_mode_control.sv ----
`timescale 1ns/100ps
`default_nettype none
module test_eeprom_mode_control;
    localparam int unsigned PULSE  = 20;
    localparam int unsigned SETTLE = 10;
    logic                 mclk, sys_rst, req_valid, req_ready, rd_valid;
    eeprom_ctl_pkg::req_t req;
    logic [7:0]           rd_data, data_out, dev_data;
    logic                 part_select, latch_strobe_n, drive_gate_n, program_level;
    logic [8:0]           byte_addr;
    logic                 data_oe_n, dev_oe_n, fault;
    logic                 clash = 1'b0;
    wire logic [7:0]      data_in;
    int                   n_fail = 0;
    int                   n_checks = 0;
    int                   cyc = 0;
    assign data_in = data_oe_n ? dev_data : data_out;
    // Both sides driving the data lines at once is a bus clash
    always @(posedge mclk)
        if (!dev_oe_n && !data_oe_n)
            clash <= 1'b1;
    eeprom_mode_control #(.PULSE_CYCLES(PULSE), .SETTLE_CYCLES(SETTLE)) dut (.mclk, .sys_rst,
        .req_valid, .req_ready, .req, .rd_valid, .rd_data, .part_select, .latch_strobe_n,
        .drive_gate_n, .program_level, .byte_addr, .data_out, .data_oe_n, .data_in);
    eeprom_dev_model #(.PULSE_MIN_NS(PULSE * 20), .SETTLE_NS(SETTLE * 20)) u_dev (
        .part_select, .latch_strobe_n, .drive_gate_n, .program_level, .byte_addr,
        .bus_in(data_in), .dev_data, .dev_oe_n, .fault);
    task automatic close_out;
        $display("checks=%0d mismatches=%0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : close_out
    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check8
    function automatic logic [7:0] init_val(input logic [8:0] a);
        return a[7:0] ^ {7'h0, a[8]} ^ 8'h5a;
    endfunction : init_val
    task automatic issue(input eeprom_ctl_pkg::op_t op, input logic [8:0] a, input logic [7:0] d);
        while (req_ready !== 1'b1)
            @(posedge mclk) #1;
        req = {op, a, d};
        req_valid = 1'b1;
        @(posedge mclk) #1;
        req_valid = 1'b0;
    endtask : issue
    task automatic read_chk(input logic [8:0] a, input logic [7:0] exp);
        int n;
        n = 0;
        issue(eeprom_ctl_pkg::OP_READ, a, 8'h00);
        while (rd_valid !== 1'b1 && n < 300)
        begin
            @(posedge mclk) #1;
            n++;
        end
        check8({7'h0, rd_valid}, 8'h01);
        check8(rd_data, exp);
    endtask : read_chk
    task automatic t_read_fresh;
        read_chk(9'h000, init_val(9'h000));
        read_chk(9'h1ff, init_val(9'h1ff));
    endtask : t_read_fresh
    task automatic t_reset_mid_read;
        issue(eeprom_ctl_pkg::OP_READ, 9'h003, 8'h00);
        repeat (20) @(posedge mclk);
        #1 sys_rst = 1'b1;
        @(posedge mclk) #1;
        sys_rst = 1'b0;
        check8({2'h0, part_select, latch_strobe_n, drive_gate_n, program_level, data_oe_n,
                req_ready}, 8'h1b);
        read_chk(9'h003, init_val(9'h003));
    endtask : t_reset_mid_read
    task automatic t_erase;
        issue(eeprom_ctl_pkg::OP_ERASE, 9'h000, 8'h00);
        read_chk(9'h000, 8'h00);
        read_chk(9'h1ff, 8'h00);
    endtask : t_erase
    task automatic t_program;
        issue(eeprom_ctl_pkg::OP_PROGRAM, 9'h005, 8'h12);
        issue(eeprom_ctl_pkg::OP_PROGRAM, 9'h005, 8'h40);
        issue(eeprom_ctl_pkg::OP_PROGRAM, 9'h1ff, 8'ha5);
        read_chk(9'h005, 8'h52);
        read_chk(9'h1ff, 8'ha5);
        read_chk(9'h006, 8'h00);
        issue(eeprom_ctl_pkg::OP_PROGRAM, 9'h005, 8'h81);
        read_chk(9'h005, 8'hd3);
    endtask : t_program
    initial
    begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_fail++;
            close_out();
        end
    end
    initial
    begin
        sys_rst = 1'b1;
        req_valid = 1'b0;
        req = '0;
        repeat (3) @(posedge mclk);
        #1 sys_rst = 1'b0;
        t_read_fresh();
        t_reset_mid_read();
        t_erase();
        t_program();
        check8({7'h0, fault}, 8'h00);
        check8({7'h0, clash}, 8'h00);
        close_out();
    end
endmodule : test_eeprom_mode_control
`default_nettype wire
